// ---- hdl/pilc_core.sv ----
// module: pi loop controller with pwm and direction outputs
//
// Functional notes
// - sense adc channel 0, drive pwm pin
// - channel 1 comparator trip forces fixed output
// - error between set point and adc data
// - proportional term is error times gain
// - integral term is accumulated error over gain
// - zero inverse integral gain disables integral
// - output never above upper limit
// - output never below lower limit while lower does not exceed upper limit
// - offset is output when terms are zero
// - loop phase bit inverts correction sign
// - fault drives fixed output value
// - threshold sets comparator trip level
// - parameters reached through index and data
// - mode high: pins are pwm, no readback
// - parameters hold nonvolatile defaults
// - run control and power config reset values
// - duty is code/128, code 127 high
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
module pilc_core #(
    parameter int ACC_W = 24,
    parameter int P_SHIFT = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // converter results
    input wire logic [7:0] i_adc_data,
    input wire logic i_adc_valid,
    input wire logic [7:0] i_cmp_code,
    // mode pin
    input wire logic i_mode_pin,
    // pwm pin, open drain
    input wire logic i_pwm_pin,
    output logic o_pwm_out,
    output logic o_pwm_oe_n,
    // direction pin, open drain
    input wire logic i_dir_pin,
    output logic o_dir_out,
    output logic o_dir_oe_n
);

    localparam int DW = $clog2(ACC_W);
    localparam int SW = (ACC_W > 26 ? ACC_W : 26) + 2;

    // refuse widths the divider and sum cannot serve
    if (ACC_W < 16 || ACC_W > 32) begin : g_acc_chk
        $error("ACC_W must lie in 16..32");
    end
    if (P_SHIFT < 0 || P_SHIFT > 16) begin : g_shift_chk
        $error("P_SHIFT must lie in 0..16");
    end

    // the whole state of the block
    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [7:0] idx;
        logic [15:0] run;
        logic [15:0] pwr;
        logic [15:0] cha;
        logic [15:0] chd;
        logic [15:0] trig;
        logic [pilc_pkg::PRM_WORDS-1:0][15:0] prm;
        pilc_pkg::pilc_fsm_t fsm;
        logic signed [8:0] err;
        logic signed [ACC_W-1:0] acc;
        logic signed [25:0] pterm;
        logic signed [ACC_W:0] iterm;
        logic [ACC_W-1:0] rem;
        logic [ACC_W-1:0] quo;
        logic [DW-1:0] dcnt;
        logic neg;
        logic [6:0] code;
        logic [6:0] duty;
        logic dir;
        logic fault;
        logic [4:0] presc;
        logic [6:0] pcnt;
        logic lvl;
        logic pwm_oe_n;
        logic dir_oe_n;
        logic [15:0] rdata;
    } pilc_state_t;

    pilc_state_t q;
    pilc_state_t n;
    pilc_pkg::pilc_cfg_t cfg;
    logic running;
    logic mode_s;
    logic prm_hit;

    // symmetric saturation keeps the magnitude inside the divider
    function automatic logic signed [ACC_W-1:0] f_sat(input logic signed [ACC_W:0] v);
        logic signed [ACC_W:0] lim;
        lim = (ACC_W+1)'((64'sd1 <<< (ACC_W - 1)) - 64'sd1);
        if (v > lim) begin
            return lim[ACC_W-1:0];
        end else if (v < -lim) begin
            return -lim[ACC_W-1:0];
        end
        return v[ACC_W-1:0];
    endfunction

    // decoded view of the store and handy levels
    assign cfg = pilc_pkg::pilc_decode(q.prm);
    assign running = q.run[pilc_pkg::RUN_EN_BIT] & ~q.run[pilc_pkg::RUN_STOP_BIT];
    assign mode_s = q.sync2[2];
    assign prm_hit = (q.idx[7:3] == pilc_pkg::PRM_PAGE);

    // next state of everything
    always_comb begin
        logic signed [8:0] adc9;
        logic signed [8:0] sp9;
        logic signed [ACC_W-1:0] acc_new;
        logic [ACC_W-1:0] t;
        logic [ACC_W-1:0] kiw;
        logic signed [SW-1:0] s;
        logic signed [SW-1:0] smax;
        logic signed [SW-1:0] smin;
        logic signed [SW-1:0] scm;
        logic signed [SW-1:0] v;
        logic pwm_en;
        n = q;
        adc9 = $signed({1'b0, i_adc_data});
        sp9 = $signed({1'b0, cfg.sp, 1'b0});
        acc_new = q.acc;
        t = {q.rem[ACC_W-2:0], q.quo[ACC_W-1]};
        kiw = ACC_W'(cfg.ki);
        scm = $signed(SW'({1'b0, cfg.cm}));
        smax = $signed(SW'({1'b0, cfg.max}));
        smin = $signed(SW'({1'b0, cfg.min}));
        s = scm + SW'(q.pterm >>> P_SHIFT) + SW'(q.iterm);
        v = s;
        pwm_en = mode_s & q.trig[pilc_pkg::TRIG_START_BIT];

        // pins from outside pass two flops first
        n.sync1 = {i_mode_pin, i_pwm_pin, i_dir_pin};
        n.sync2 = q.sync1;

        // register writes
        if (i_wr) begin
            case (i_addr)
                pilc_pkg::ADDR_CHA: n.cha = i_wdata;
                pilc_pkg::ADDR_CHD: n.chd = i_wdata;
                pilc_pkg::ADDR_PWR: n.pwr = i_wdata;
                pilc_pkg::ADDR_RUN: n.run = i_wdata;
                pilc_pkg::ADDR_IDX: n.idx = i_wdata[7:0];
                pilc_pkg::ADDR_TRIG: n.trig = i_wdata;
                pilc_pkg::ADDR_DAT: begin
                    if (prm_hit) begin
                        n.prm[q.idx[2:0]] = i_wdata;
                    end
                end
                default: ;
            endcase
        end

        // register reads, answered one cycle later
        n.rdata = '0;
        if (i_rd) begin
            case (i_addr)
                pilc_pkg::ADDR_CHA: n.rdata = q.cha;
                pilc_pkg::ADDR_CHD: n.rdata = q.chd;
                pilc_pkg::ADDR_PWR: n.rdata = q.pwr;
                pilc_pkg::ADDR_RUN: n.rdata = q.run;
                pilc_pkg::ADDR_IDX: n.rdata = {8'h00, q.idx};
                pilc_pkg::ADDR_TRIG: n.rdata = q.trig;
                pilc_pkg::ADDR_STAT: begin
                    n.rdata = {running, q.fault, q.dir, q.sync2[1], q.sync2[0],
                        q.code, 4'h0};
                end
                pilc_pkg::ADDR_DAT: begin
                    // pins serve the pwm while mode is high: store is hidden
                    if (prm_hit && !mode_s) begin
                        n.rdata = q.prm[q.idx[2:0]];
                    end
                end
                default: n.rdata = '0;
            endcase
        end

        // loop sequencer
        case (q.fsm)
            pilc_pkg::ST_WAIT: begin
                if (running && i_adc_valid) begin
                    // phase bit flips the sign of the correction
                    n.err = cfg.pol ? adc9 - sp9 : sp9 - adc9;
                    n.fsm = pilc_pkg::ST_ERR;
                end
            end
            pilc_pkg::ST_ERR: begin
                n.pterm = q.err * $signed({1'b0, cfg.kp});
                if (cfg.ki == '0) begin
                    // no accumulation either, so no windup while disabled
                    n.iterm = '0;
                    n.fsm = pilc_pkg::ST_SUM;
                end else begin
                    acc_new = f_sat((ACC_W+1)'(q.acc) + (ACC_W+1)'(q.err));
                    n.acc = acc_new;
                    n.neg = acc_new[ACC_W-1];
                    n.quo = acc_new[ACC_W-1] ? ACC_W'(-acc_new) : ACC_W'(acc_new);
                    n.rem = '0;
                    n.dcnt = DW'(ACC_W - 1);
                    n.fsm = pilc_pkg::ST_DIV;
                end
            end
            pilc_pkg::ST_DIV: begin
                // restoring division, one quotient bit per cycle
                if (t >= kiw) begin
                    n.rem = t - kiw;
                    n.quo = {q.quo[ACC_W-2:0], 1'b1};
                end else begin
                    n.rem = t;
                    n.quo = {q.quo[ACC_W-2:0], 1'b0};
                end
                n.dcnt = q.dcnt - 1'b1;
                if (q.dcnt == '0) begin
                    n.fsm = pilc_pkg::ST_SUM;
                end
            end
            pilc_pkg::ST_SUM: begin
                // quotient of the previous cycle is complete in q.quo
                // a quotient left from an earlier gain must not leak in once disabled
                if (cfg.ki == '0) begin
                    n.iterm = '0;
                end else begin
                    n.iterm = q.neg ? -$signed({1'b0, q.quo}) : $signed({1'b0, q.quo});
                end
                n.fsm = pilc_pkg::ST_WAIT;
            end
            default: n.fsm = pilc_pkg::ST_WAIT;
        endcase

        // result is taken one cycle after the integral term settles
        if (q.fsm == pilc_pkg::ST_SUM && q.iterm == n.iterm) begin
            if (v < smin) begin
                v = smin;
            end
            if (v > smax) begin
                v = smax;
            end
            n.code = v[6:0];
            n.dir = (s >= scm);
        end else if (q.fsm == pilc_pkg::ST_SUM) begin
            n.fsm = pilc_pkg::ST_SUM;
        end

        // stopping mid-cycle abandons the computation
        if (!running) begin
            n.fsm = pilc_pkg::ST_WAIT;
        end

        // fault comparator and override after clamping
        n.fault = (i_cmp_code > {cfg.thr, 1'b0});
        n.duty = q.fault ? cfg.fix : q.code;

        // pwm period of 128 steps, each frq clocks long
        if (cfg.frq == '0) begin
            n.presc = '0;
            n.pcnt = '0;
        end else if (q.presc >= cfg.frq - 5'h1) begin
            n.presc = '0;
            n.pcnt = q.pcnt + 7'h1;
        end else begin
            n.presc = q.presc + 5'h1;
        end
        // the 127/128 step is skipped so the top code is a steady high
        n.lvl = pwm_en && (cfg.frq != '0) &&
            (q.duty == pilc_pkg::CODE_FULL || q.pcnt < q.duty);

        // open drain: pins released while mode is low
        n.pwm_oe_n = !(mode_s && !q.lvl);
        n.dir_oe_n = !(mode_s && !q.dir);
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            q <= '0;
            q.run <= pilc_pkg::RST_RUN;
            q.pwr <= pilc_pkg::RST_PWR;
            q.cha <= pilc_pkg::RST_CHA;
            q.chd <= pilc_pkg::RST_CHD;
            q.trig <= pilc_pkg::RST_TRIG;
            q.prm[pilc_pkg::W_MAX] <= pilc_pkg::DEF_MAX;
            q.prm[pilc_pkg::W_MIN] <= pilc_pkg::DEF_MIN;
            q.prm[pilc_pkg::W_SP] <= pilc_pkg::DEF_SP;
            q.prm[pilc_pkg::W_KP] <= pilc_pkg::DEF_KP;
            q.prm[pilc_pkg::W_THR] <= pilc_pkg::DEF_THR;
            q.prm[pilc_pkg::W_CM] <= pilc_pkg::DEF_CM;
            q.prm[pilc_pkg::W_KI] <= pilc_pkg::DEF_KI;
            q.prm[pilc_pkg::W_FIX] <= pilc_pkg::DEF_FIX;
            q.fsm <= pilc_pkg::ST_WAIT;
            q.pwm_oe_n <= 1'b1;
            q.dir_oe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // outputs from flops or tied low; open drain pins only ever pull low
    assign o_rdata = q.rdata;
    assign o_pwm_out = 1'b0;
    assign o_pwm_oe_n = q.pwm_oe_n;
    assign o_dir_out = 1'b0;
    assign o_dir_oe_n = q.dir_oe_n;

    // checks on the loop result
    max_clamp_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.fsm == pilc_pkg::ST_SUM && n.fsm == pilc_pkg::ST_WAIT && running)
        |=> q.code <= $past(cfg.max)) else $error("code above upper limit");
    min_clamp_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.fsm == pilc_pkg::ST_SUM && n.fsm == pilc_pkg::ST_WAIT && running
        && cfg.min <= cfg.max)
        |=> q.code >= $past(cfg.min)) else $error("code below lower limit");
    ki_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.fsm == pilc_pkg::ST_ERR && cfg.ki == '0 && running)
        |=> q.fsm == pilc_pkg::ST_SUM ##1 q.iterm == '0)
        else $error("integral not disabled");
    div_len_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(q.fsm == pilc_pkg::ST_DIV) |-> ##[1:33] (q.fsm != pilc_pkg::ST_DIV))
        else $error("divider does not finish");

    // checks on the fault path
    fault_fix_a: assert property (@(posedge i_clk) disable iff (i_rst)
        q.fault |=> q.duty == $past(cfg.fix)) else $error("fault value not forced");
    trip_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmp_code > {cfg.thr, 1'b0} && $stable(cfg.fix))
        |=> ##1 q.duty == $past(cfg.fix)) else $error("trip did not force output");
    fault_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!q.fault) |=> q.duty == $past(q.code)) else $error("duty not from loop code");

    // checks on the pwm level
    pwm_full_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_s && q.trig[pilc_pkg::TRIG_START_BIT] && cfg.frq != '0
        && q.duty == pilc_pkg::CODE_FULL) |=> q.lvl) else $error("code 127 not high");
    pwm_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.duty == '0) |=> !q.lvl ##1 (!$past(mode_s) || !o_pwm_oe_n))
        else $error("code 0 not low");

    // checks on the register port and pin release
    hide_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_rd && i_addr == pilc_pkg::ADDR_DAT && mode_s) |=> o_rdata == '0)
        else $error("store read while mode high");
    pin_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!mode_s) |=> (o_pwm_oe_n && o_dir_oe_n)) else $error("pin driven in mode low");
    store_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == pilc_pkg::ADDR_DAT && prm_hit)
        |=> q.prm[$past(q.idx[2:0])] == $past(i_wdata)) else $error("store not written");
    stop_run_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wr && i_addr == pilc_pkg::ADDR_RUN && i_wdata == 16'h0004)
        |=> !running ##1 q.fsm == pilc_pkg::ST_WAIT) else $error("stop ignored");
    // read data only ever stand in the cycle after a read strobe
    read_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_rd) |=> o_rdata == '0) else $error("read data outside read cycle");
    dir_pin_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (mode_s && !q.dir) |=> !o_dir_oe_n) else $error("direction pin not driven");

endmodule

// ---- pkg/pilc_pkg.sv ----
// package: register map, parameter store layout and types of the pi loop controller
package pilc_pkg;

    // register map at the printed offsets
    localparam logic [7:0] ADDR_CHA = 8'h03;
    localparam logic [7:0] ADDR_CHD = 8'h15;
    localparam logic [7:0] ADDR_PWR = 8'h1F;
    localparam logic [7:0] ADDR_RUN = 8'h27;
    // indirect access, trigger and status
    localparam logic [7:0] ADDR_IDX = 8'h30;
    localparam logic [7:0] ADDR_DAT = 8'h31;
    localparam logic [7:0] ADDR_TRIG = 8'h32;
    localparam logic [7:0] ADDR_STAT = 8'h33;

    // register reset values
    localparam logic [15:0] RST_CHA = 16'h0405;
    localparam logic [15:0] RST_CHD = 16'h0401;
    localparam logic [15:0] RST_PWR = 16'h13F9;
    localparam logic [15:0] RST_RUN = 16'h0003;
    localparam logic [15:0] RST_TRIG = 16'h0000;

    // parameter store: locations 0x20 to 0x27
    localparam logic [4:0] PRM_PAGE = 5'h04;
    localparam int PRM_WORDS = 8;
    localparam int W_MAX = 0;
    localparam int W_MIN = 1;
    localparam int W_SP = 2;
    localparam int W_KP = 3;
    localparam int W_THR = 4;
    localparam int W_CM = 5;
    localparam int W_KI = 6;
    localparam int W_FIX = 7;

    // nonvolatile defaults of the parameter words
    localparam logic [15:0] DEF_MAX = 16'h7E00;
    localparam logic [15:0] DEF_MIN = 16'h0000;
    localparam logic [15:0] DEF_SP = 16'h0200;
    localparam logic [15:0] DEF_KP = 16'h0032;
    localparam logic [15:0] DEF_THR = 16'h8000;
    localparam logic [15:0] DEF_CM = 16'h0000;
    localparam logic [15:0] DEF_KI = 16'h0000;
    localparam logic [15:0] DEF_FIX = 16'h8000;

    // field positions
    localparam int F7_HI = 15;
    localparam int F7_LO = 9;
    localparam int SP_HI = 9;
    localparam int SP_LO = 3;
    localparam int CM_HI = 11;
    localparam int CM_LO = 5;
    localparam int FRQ_HI = 4;
    localparam int FRQ_LO = 0;
    localparam int POL_BIT = 0;
    localparam int RUN_EN_BIT = 0;
    localparam int RUN_STOP_BIT = 2;
    localparam int TRIG_START_BIT = 0;

    // pwm code that means a steady high level
    localparam logic [6:0] CODE_FULL = 7'h7F;

    // decoded controller settings
    typedef struct packed {
        logic [6:0] max;
        logic [6:0] min;
        logic [6:0] sp;
        logic [6:0] cm;
        logic [6:0] fix;
        logic [6:0] thr;
        logic [15:0] kp;
        logic [15:0] ki;
        logic pol;
        logic [4:0] frq;
    } pilc_cfg_t;

    // loop sequencer states, gray along the path through the divider
    typedef enum logic [2:0] {
        ST_WAIT = 3'h0,
        ST_ERR = 3'h1,
        ST_DIV = 3'h3,
        ST_SUM = 3'h2
    } pilc_fsm_t;

    // split the parameter words into fields
    function automatic pilc_cfg_t pilc_decode(input logic [PRM_WORDS-1:0][15:0] w);
        pilc_cfg_t c;
        c.max = w[W_MAX][F7_HI:F7_LO];
        c.min = w[W_MIN][F7_HI:F7_LO];
        c.sp = w[W_SP][SP_HI:SP_LO];
        c.cm = w[W_CM][CM_HI:CM_LO];
        c.fix = w[W_FIX][F7_HI:F7_LO];
        c.thr = w[W_THR][F7_HI:F7_LO];
        c.kp = w[W_KP];
        c.ki = w[W_KI];
        c.pol = w[W_FIX][POL_BIT];
        c.frq = w[W_MIN][FRQ_HI:FRQ_LO];
        return c;
    endfunction

endpackage

// ---- sim/pilc_pin_model.sv ----
// pin model: pull-up resistors on the open-drain pwm and direction lines
`timescale 1ns/10ps
module pilc_pin_model (
    // drive from the controller
    input wire logic i_pwm_out,
    input wire logic i_pwm_oe_n,
    input wire logic i_dir_out,
    input wire logic i_dir_oe_n,
    // resolved line levels
    output logic o_pwm_line,
    output logic o_dir_line
);
    // a released line floats to the pull-up level, never to a stale value
    assign o_pwm_line = i_pwm_oe_n ? 1'b1 : i_pwm_out;
    assign o_dir_line = i_dir_oe_n ? 1'b1 : i_dir_out;
endmodule

// ---- sim/tb.sv ----
// testbench: register map, loop arithmetic, integral, fault override and pwm duty
`timescale 1ns/10ps
module tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] o_rdata;
    logic [7:0] i_adc_data = 8'h00;
    logic i_adc_valid = 1'b0;
    logic [7:0] i_cmp_code = 8'h00;
    logic i_mode_pin = 1'b0;
    logic pwm_line;
    logic dir_line;
    logic o_pwm_out;
    logic o_pwm_oe_n;
    logic o_dir_out;
    logic o_dir_oe_n;
    int fail_count = 0;
    int comparisons = 0;
    logic [15:0] rv;

    // 100 MHz clock
    always #5 i_clk = ~i_clk;

    pilc_core i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_adc_data(i_adc_data),
        .i_adc_valid(i_adc_valid), .i_cmp_code(i_cmp_code), .i_mode_pin(i_mode_pin),
        .i_pwm_pin(pwm_line), .o_pwm_out(o_pwm_out), .o_pwm_oe_n(o_pwm_oe_n),
        .i_dir_pin(dir_line), .o_dir_out(o_dir_out), .o_dir_oe_n(o_dir_oe_n)
    );

    pilc_pin_model i_pins (
        .i_pwm_out(o_pwm_out), .i_pwm_oe_n(o_pwm_oe_n), .i_dir_out(o_dir_out),
        .i_dir_oe_n(o_dir_oe_n), .o_pwm_line(pwm_line), .o_dir_line(dir_line)
    );

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    // one-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        rd(a, rv);
        chk(rv, exp);
    endtask

    // indirect parameter write through index and data registers
    task automatic prm(input logic [7:0] idx, input logic [15:0] d);
        wr(pilc_pkg::ADDR_IDX, {8'h00, idx});
        wr(pilc_pkg::ADDR_DAT, d);
    endtask

    // host preparation before touching the parameter store
    task automatic halt_host;
        wr(pilc_pkg::ADDR_RUN, 16'h0004);
        i_mode_pin <= 1'b0;
        wr(pilc_pkg::ADDR_TRIG, 16'h0000);
        repeat (3) @(posedge i_clk);
    endtask

    // restart the loop; the mode pin is synced by two flops, so allow a few edges
    task automatic go(input logic pwm);
        wr(pilc_pkg::ADDR_RUN, 16'h0003);
        wr(pilc_pkg::ADDR_TRIG, {15'h0000, pwm});
        i_mode_pin <= pwm;
        repeat (4) @(posedge i_clk);
    endtask

    // limits 0x10..0x50, set point 0x20 (0x40 in adc units), offset 0x30
    task automatic cfg(input logic [15:0] kp, input logic [15:0] ki, input logic [15:0] fixw);
        prm(8'h20, 16'hA000);
        prm(8'h21, 16'h2001);
        prm(8'h22, 16'h0100);
        prm(8'h23, kp);
        prm(8'h24, 16'h8000);
        prm(8'h25, 16'h0600);
        prm(8'h26, ki);
        prm(8'h27, fixw);
    endtask

    // one adc sample, then code and direction from the status word
    task automatic sample(input logic [7:0] adc, input int wait_n, input logic [6:0] code,
                          input logic dir);
        @(posedge i_clk);
        i_adc_data <= adc;
        i_adc_valid <= 1'b1;
        @(posedge i_clk);
        i_adc_valid <= 1'b0;
        repeat (wait_n) @(posedge i_clk);
        rd(pilc_pkg::ADDR_STAT, rv);
        chk({9'h000, rv[10:4]}, {9'h000, code});
        chk({15'h0000, rv[13]}, {15'h0000, dir});
    endtask

    task automatic test_regs;
        logic [15:0] defs [8];
        defs = '{16'h7E00, 16'h0000, 16'h0200, 16'h0032, 16'h8000, 16'h0000, 16'h0000, 16'h8000};
        rchk(pilc_pkg::ADDR_CHA, 16'h0405);
        rchk(pilc_pkg::ADDR_CHD, 16'h0401);
        rchk(pilc_pkg::ADDR_PWR, 16'h13F9);
        rchk(pilc_pkg::ADDR_RUN, 16'h0003);
        rchk(8'h50, 16'h0000);
        halt_host;
        rchk(pilc_pkg::ADDR_RUN, 16'h0004);
        for (int i = 0; i < 8; i++) begin
            wr(pilc_pkg::ADDR_IDX, 16'h0020 + 16'(i));
            rchk(pilc_pkg::ADDR_DAT, defs[i]);
        end
        prm(8'h23, 16'hA5C3);
        rchk(pilc_pkg::ADDR_DAT, 16'hA5C3);
        prm(8'h28, 16'h1234);
        rchk(pilc_pkg::ADDR_DAT, 16'h0000);
        wr(pilc_pkg::ADDR_PWR, 16'h13F8);
        rchk(pilc_pkg::ADDR_PWR, 16'h13F8);
        wr(pilc_pkg::ADDR_CHA, 16'h0401);
        rchk(pilc_pkg::ADDR_CHA, 16'h0401);
        $display("test_regs done");
    endtask

    task automatic test_loop;
        halt_host;
        cfg(16'h0100, 16'h0000, 16'hFE00);
        go(1'b0);
        sample(8'h30, 6, 7'h40, 1'b1);
        sample(8'h40, 6, 7'h30, 1'b1);
        sample(8'h00, 6, 7'h50, 1'b1);
        sample(8'hFF, 6, 7'h10, 1'b0);
        halt_host;
        cfg(16'h0100, 16'h0000, 16'hFE01);
        // mode high here so the direction pin shows the negative correction
        go(1'b1);
        sample(8'h30, 6, 7'h20, 1'b0);
        chk({15'h0000, rv[11]}, 16'h0000);
        chk({15'h0000, dir_line}, 16'h0000);
        halt_host;
        // a stopped loop ignores samples, so the last code stands
        sample(8'h00, 6, 7'h20, 1'b0);
        $display("test_loop done");
    endtask

    task automatic test_integ;
        halt_host;
        cfg(16'h0000, 16'h0000, 16'hFE00);
        go(1'b0);
        sample(8'h30, 6, 7'h30, 1'b1);
        halt_host;
        cfg(16'h0000, 16'h0001, 16'hFE00);
        go(1'b0);
        sample(8'h30, 32, 7'h40, 1'b1);
        sample(8'h30, 32, 7'h50, 1'b1);
        // back to no integral: an old quotient must not come back
        halt_host;
        prm(8'h26, 16'h0000);
        go(1'b0);
        sample(8'h30, 6, 7'h30, 1'b1);
        $display("test_integ done");
    endtask

    task automatic test_fault;
        logic [6:0] fix [5];
        int n;
        fix = '{7'h7F, 7'h20, 7'h01, 7'h7E, 7'h00};
        for (int i = 0; i < 5; i++) begin
            halt_host;
            cfg(16'h0100, 16'h0000, {fix[i], 9'h000});
            i_cmp_code <= 8'h81;
            go(1'b1);
            // stop the loop before touching the store; mode stays high
            wr(pilc_pkg::ADDR_RUN, 16'h0004);
            rchk(pilc_pkg::ADDR_DAT, 16'h0000);
            rd(pilc_pkg::ADDR_STAT, rv);
            chk({15'h0000, rv[14]}, 16'h0001);
            // let the new duty reach the pin before counting one 128-step period
            repeat (140) @(posedge i_clk);
            n = 0;
            repeat (128) begin
                @(negedge i_clk);
                n += int'(pwm_line);
            end
            chk(16'(n), (fix[i] == 7'h7F) ? 16'h0080 : {9'h000, fix[i]});
        end
        // at the threshold itself the comparator stays quiet
        i_cmp_code <= 8'h80;
        repeat (4) @(posedge i_clk);
        rd(pilc_pkg::ADDR_STAT, rv);
        chk({15'h0000, rv[14]}, 16'h0000);
        halt_host;
        @(negedge i_clk);
        chk({15'h0000, pwm_line}, 16'h0001);
        $display("test_fault done");
    endtask

    // watchdog: the tests need a few thousand cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        finish_test;
    end

    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        test_regs;
        test_loop;
        test_integ;
        test_fault;
        finish_test;
    end
endmodule
